/* File: design/rtctw_pkg.sv */
// Constants for the real-time clock counters and periodic event flags
`default_nettype none
package rtctw_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 31250000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int ADDR_W = 20;
    localparam int CTL_IDX = 'h56C0;
    localparam int IEN_IDX = 'h56C2;
    localparam int FLG_IDX = 'h56C4;
    localparam int MS_IDX = 'h56C6;
    localparam int HR_IDX = 'h56C8;
    localparam logic [ADDR_W-1:0] CTL_ADDR = ADDR_W'(CTL_IDX * 4);
    localparam logic [ADDR_W-1:0] IEN_ADDR = ADDR_W'(IEN_IDX * 4);
    localparam logic [ADDR_W-1:0] FLG_ADDR = ADDR_W'(FLG_IDX * 4);
    localparam logic [ADDR_W-1:0] MS_ADDR = ADDR_W'(MS_IDX * 4);
    localparam logic [ADDR_W-1:0] HR_ADDR = ADDR_W'(HR_IDX * 4);
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_H12_BIT = 4;
    localparam int CTL_BCD_BIT = 5;
    localparam int CTL_RUNST_BIT = 8;
    localparam int HR_PM_BIT = 7;
    localparam int FLG_W = 10;
    localparam int EV_32HZ = 0;
    localparam int EV_8HZ = 1;
    localparam int EV_4HZ = 2;
    localparam int EV_1HZ = 3;
    localparam int EV_10S = 4;
    localparam int EV_1M = 5;
    localparam int EV_10M = 6;
    localparam int EV_1H = 7;
    localparam int EV_HD = 8;
    localparam int EV_DAY = 9;
    localparam logic [6:0] SEC_MAX_BIN = 7'h3B;
    localparam logic [6:0] SEC_MAX_BCD = 7'h59;
    localparam logic [6:0] H24_MAX_BIN = 7'h17;
    localparam logic [6:0] H24_MAX_BCD = 7'h23;
    localparam logic [6:0] H12_MAX_BIN = 7'h0B;
    localparam logic [6:0] H12_MAX_BCD = 7'h11;
    localparam logic [4:0] SUB_LAST = 5'h1F;
    localparam logic [FLG_W-1:0] FLG_RESET = 10'h000;
endpackage
`default_nettype wire

/* File: design/rtctw_top.sv */
// Real-time clock counters, periodic event flags and wake logic with APB slave
//
// Local design decision: the APB register port.
`default_nettype none
module rtctw_top #(
    parameter int TICK_CYCLES = rtctw_pkg::TICK_CYCLES_DEF
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [rtctw_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic cpu_sleep_i,
    input wire logic cpu_halt_i,
    output logic irq_o,
    output logic wake_o,
    output logic low_speed_osc_en_o,
    output logic high_speed_osc_en_o
);
    import rtctw_pkg::*;

    localparam int PW = $clog2(TICK_CYCLES);
    localparam logic [PW-1:0] PRESC_LAST = PW'(TICK_CYCLES - 1);

    // A one-state prescaler would leave the tick compare with nothing to count
    if (TICK_CYCLES < 2) begin : g_tick_check
        $error("TICK_CYCLES must be at least 2");
    end

    // Returns {wrap, next} for a counter field in either coding
    function automatic logic [7:0] cnt_inc(input logic [6:0] v, input logic [6:0] mx,
                                           input logic bcd);
        logic [7:0] r;
        r = {1'b0, v + 7'h01};
        if (v == mx) begin
            r = 8'h80;
        end else if (bcd && v[3:0] == 4'h9) begin
            r = {1'b0, v[6:4] + 3'h1, 4'h0};
        end
        return r;
    endfunction

    function automatic logic is_tenth(input logic [6:0] v, input logic bcd);
        return bcd ? (v[3:0] == 4'h0) : ((v % 7'h0A) == 7'h00);
    endfunction

    logic run_reg, run_next, runst_reg, runst_next;
    logic bcd_reg, bcd_next, h12_reg, h12_next;
    logic [FLG_W-1:0] ien_reg, ien_next, flg_reg, flg_next, ev;
    logic [6:0] sec_reg, sec_next, min_reg, min_next;
    logic [5:0] hour_reg, hour_next;
    logic pm_reg, pm_next;
    logic [PW-1:0] presc_reg, presc_next;
    logic [4:0] sub_reg, sub_next;
    logic [31:0] prdata_reg, prdata_next, rd_mux;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic irq_reg, irq_next, wake_reg, wake_next;
    logic lso_reg, lso_next, hso_reg, hso_next;
    logic tick, sec_tick, wr, mapped;
    logic [7:0] sinc, minc, hinc;
    logic [6:0] hmax;

    always_comb begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        // Reserved bits stay zero in every read word
        case (paddr_i)
            CTL_ADDR: begin
                rd_mux[CTL_RUN_BIT] = run_reg;
                rd_mux[CTL_H12_BIT] = h12_reg;
                rd_mux[CTL_BCD_BIT] = bcd_reg;
                rd_mux[CTL_RUNST_BIT] = runst_reg;
            end
            IEN_ADDR: rd_mux[FLG_W-1:0] = ien_reg;
            FLG_ADDR: rd_mux[FLG_W-1:0] = flg_reg;
            MS_ADDR: rd_mux[15:0] = {1'b0, min_reg, 1'b0, sec_reg};
            HR_ADDR: rd_mux[15:0] = {8'h00, pm_reg, 1'b0, hour_reg};
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        wr = psel_i && penable_i && pready_reg && pwrite_i;
        pready_next = psel_i && penable_i && !pready_reg;
        pslverr_next = pready_next && !mapped;
        prdata_next = pready_next ? rd_mux : prdata_reg;
        run_next = run_reg;
        bcd_next = bcd_reg;
        h12_next = h12_reg;
        ien_next = ien_reg;
        sec_next = sec_reg;
        min_next = min_reg;
        hour_next = hour_reg;
        pm_next = pm_reg;
        sub_next = sub_reg;
        ev = '0;
        sinc = 8'h00;
        minc = 8'h00;
        hinc = 8'h00;
        hmax = h12_reg ? (bcd_reg ? H12_MAX_BCD : H12_MAX_BIN)
                       : (bcd_reg ? H24_MAX_BCD : H24_MAX_BIN);
        // The time base runs on the core clock, never on the bus handshake
        tick = run_reg && (presc_reg == PRESC_LAST);
        presc_next = (!run_reg || tick) ? '0 : presc_reg + 1'b1;
        sec_tick = tick && (sub_reg == SUB_LAST);
        if (tick) begin
            sub_next = sub_reg + 5'h01;
            ev[EV_32HZ] = 1'b1;
            ev[EV_8HZ] = (sub_reg[1:0] == 2'h3);
            ev[EV_4HZ] = (sub_reg[2:0] == 3'h7);
        end
        if (sec_tick) begin
            ev[EV_1HZ] = 1'b1;
            sinc = cnt_inc(sec_reg, bcd_reg ? SEC_MAX_BCD : SEC_MAX_BIN, bcd_reg);
            sec_next = sinc[6:0];
            ev[EV_10S] = is_tenth(sinc[6:0], bcd_reg);
            if (sinc[7]) begin
                minc = cnt_inc(min_reg, bcd_reg ? SEC_MAX_BCD : SEC_MAX_BIN, bcd_reg);
                min_next = minc[6:0];
                ev[EV_1M] = 1'b1;
                ev[EV_10M] = is_tenth(minc[6:0], bcd_reg);
                if (minc[7]) begin
                    hinc = cnt_inc({1'b0, hour_reg}, hmax, bcd_reg);
                    hour_next = hinc[5:0];
                    ev[EV_1H] = 1'b1;
                    if (h12_reg) begin
                        // Indicator flips at each half-day wrap of the 12-hour field
                        ev[EV_HD] = hinc[7];
                        ev[EV_DAY] = hinc[7] && pm_reg;
                        pm_next = pm_reg ^ hinc[7];
                    end else begin
                        ev[EV_HD] = hinc[7] || (hinc[5:0] == (bcd_reg ? 6'h12 : 6'h0C));
                        ev[EV_DAY] = hinc[7];
                        pm_next = !hinc[7] && (ev[EV_HD] || pm_reg);
                    end
                end
            end
        end
        // Set wins over a same-cycle write-one clear
        flg_next = flg_reg | ev;
        if (wr) begin
            case (paddr_i)
                CTL_ADDR: begin
                    run_next = pwdata_i[CTL_RUN_BIT];
                    h12_next = pwdata_i[CTL_H12_BIT];
                    bcd_next = pwdata_i[CTL_BCD_BIT];
                end
                IEN_ADDR: ien_next = pwdata_i[FLG_W-1:0];
                FLG_ADDR: flg_next = (flg_reg & ~pwdata_i[FLG_W-1:0]) | ev;
                MS_ADDR: begin
                    // A write overrides a carry landing in the same cycle
                    min_next = pwdata_i[14:8];
                    sec_next = pwdata_i[6:0];
                end
                HR_ADDR: begin
                    pm_next = pwdata_i[HR_PM_BIT];
                    hour_next = pwdata_i[5:0];
                end
                default: ;
            endcase
        end
        runst_next = run_reg;
        irq_next = |(flg_reg & ien_reg);
        // In sleep only a running clock can raise events at all
        wake_next = irq_next && (cpu_halt_i || (cpu_sleep_i && run_reg));
        lso_next = !(cpu_sleep_i && !run_reg);
        hso_next = !cpu_sleep_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            run_reg <= 1'b0;
            runst_reg <= 1'b0;
            bcd_reg <= 1'b0;
            h12_reg <= 1'b0;
            ien_reg <= '0;
            flg_reg <= FLG_RESET;
            sec_reg <= 7'h00;
            min_reg <= 7'h00;
            hour_reg <= 6'h00;
            pm_reg <= 1'b0;
            presc_reg <= '0;
            sub_reg <= 5'h00;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            lso_reg <= 1'b1;
            hso_reg <= 1'b1;
        end else if (ce_i) begin
            run_reg <= run_next;
            runst_reg <= runst_next;
            bcd_reg <= bcd_next;
            h12_reg <= h12_next;
            ien_reg <= ien_next;
            flg_reg <= flg_next;
            sec_reg <= sec_next;
            min_reg <= min_next;
            hour_reg <= hour_next;
            pm_reg <= pm_next;
            presc_reg <= presc_next;
            sub_reg <= sub_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            lso_reg <= lso_next;
            hso_reg <= hso_next;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign irq_o = irq_reg;
    assign wake_o = wake_reg;
    assign low_speed_osc_en_o = lso_reg;
    assign high_speed_osc_en_o = hso_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    a_irq_tracks_flags: assert property (
        ce_i |=> irq_o == (|($past(flg_reg) & $past(ien_reg))))
        else $error("irq does not follow enabled flags");
    a_flag_w1c: assert property (
        ce_i && wr && paddr_i == FLG_ADDR && pwdata_i[EV_DAY] && !ev[EV_DAY]
        |=> !flg_reg[EV_DAY])
        else $error("write one did not clear flag");
    a_flag_sticky: assert property (
        ce_i && flg_reg[EV_1H] && !(wr && paddr_i == FLG_ADDR) |=> flg_reg[EV_1H])
        else $error("flag dropped without clear");
    a_tick_sets_32hz: assert property (
        ce_i && tick |=> flg_reg[EV_32HZ])
        else $error("32 Hz flag not set on tick");
    a_sec_range: assert property (
        ce_i && sec_tick && !wr && sec_reg == SEC_MAX_BIN && !bcd_reg
        |=> sec_reg == 7'h00 && flg_reg[EV_1M])
        else $error("second wrap missing carry");
    a_hour12_range: assert property (
        h12_reg && !wr && {1'b0, hour_reg} <= hmax
        |=> {1'b0, hour_reg} <= hmax)
        else $error("12-hour field left range");
    a_ms_reserved: assert property (
        pready_o && $past(paddr_i) == MS_ADDR && !pslverr_o
        |-> prdata_o[15] == 1'b0 && prdata_o[7] == 1'b0)
        else $error("reserved minute bits not zero");
    a_sleep_oscs: assert property (
        ce_i && cpu_sleep_i && !run_reg |=> !low_speed_osc_en_o && !high_speed_osc_en_o)
        else $error("oscillators not stopped in sleep");
    a_sleep_run: assert property (
        ce_i && cpu_sleep_i && run_reg |=> low_speed_osc_en_o && !high_speed_osc_en_o)
        else $error("low-speed clock stopped while running");
    a_wake_halt: assert property (
        ce_i && cpu_halt_i && |(flg_reg & ien_reg) |=> wake_o)
        else $error("halt not cancelled by request");
    a_wake_sleep: assert property (
        ce_i && cpu_sleep_i && run_reg && |(flg_reg & ien_reg) |=> wake_o)
        else $error("running clock did not wake from sleep");
    a_stop_no_wake: assert property (
        ce_i && cpu_sleep_i && !cpu_halt_i && !run_reg |=> !wake_o)
        else $error("stopped clock woke the CPU from sleep");
    a_osc_awake: assert property (
        ce_i && !cpu_sleep_i |=> low_speed_osc_en_o && high_speed_osc_en_o)
        else $error("oscillator disabled while awake");

    // Values right after reset
    a_flag_reset: assert property (
        $fell(reset_i) |-> flg_reg == FLG_RESET)
        else $error("flags not clear after reset");
    a_mode_reset: assert property (
        $fell(reset_i) |-> !bcd_reg && !h12_reg)
        else $error("coding or hour format not default after reset");

    // Flag and counter behaviour
    a_w1c_keep: assert property (
        ce_i && wr && paddr_i == FLG_ADDR && flg_reg[EV_1HZ] && !pwdata_i[EV_1HZ]
        |=> flg_reg[EV_1HZ])
        else $error("write zero cleared a flag");
    a_ten_sec: assert property (
        ce_i && sec_tick && !wr && sinc[6:0] == 7'h00 |=> flg_reg[EV_10S])
        else $error("ten-second flag not set");
    a_min_carry: assert property (
        ce_i && sec_tick && !wr && bcd_reg && sec_reg == SEC_MAX_BCD && min_reg == SEC_MAX_BCD
        |=> min_reg == 7'h00 && flg_reg[EV_1H])
        else $error("minute wrap missing carry");
    a_pm_toggle: assert property (
        ce_i && sec_tick && !wr && h12_reg && sinc[7] && minc[7] && hinc[7]
        |=> pm_reg != $past(pm_reg))
        else $error("afternoon indicator did not flip");
    a_day_event: assert property (
        ce_i && sec_tick && !wr && !h12_reg && sinc[7] && minc[7] && hinc[7]
        |=> flg_reg[EV_DAY] && flg_reg[EV_HD] && !pm_reg)
        else $error("day wrap did not raise day events");

    // Bus answer and clock enable
    a_hr_reserved: assert property (
        pready_o && $past(paddr_i) == HR_ADDR && !pslverr_o
        |-> prdata_o[15:8] == 8'h00 && prdata_o[6] == 1'b0)
        else $error("reserved hour bits not zero");
    a_err_zero: assert property (
        pready_o && pslverr_o |-> prdata_o == 32'h0000_0000)
        else $error("refused access returned data");
    a_ready_pulse: assert property (
        ce_i && pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    a_ce_freeze: assert property (
        !ce_i |=> $stable(flg_reg) && $stable(sec_reg) && $stable(pready_o))
        else $error("state moved while clock enable low");
endmodule
`default_nettype wire

/* File: bench/rtctw_tb.sv */
// Self-checking bench for the clock counters, event flags and wake outputs
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rtctw_pkg::*;
    typedef struct {logic [31:0] data; logic err; logic chk;} rtctw_exp_type;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic cpu_sleep = 1'b0;
    logic cpu_halt = 1'b0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, irq_o, wake_o, low_osc_o, high_osc_o;
    rtctw_exp_type exp_q[$];
    rtctw_exp_type e;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'hB400;
    logic [31:0] v;
    // Short prescaler: one second is 128 clock cycles
    rtctw_top #(.TICK_CYCLES(4)) DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .cpu_sleep_i(cpu_sleep), .cpu_halt_i(cpu_halt), .irq_o(irq_o), .wake_o(wake_o),
        .low_speed_osc_en_o(low_osc_o), .high_speed_osc_en_o(high_osc_o));
    always #5 core_clk_i = ~core_clk_i;
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_bus(input logic [31:0] got, input logic gerr, input rtctw_exp_type x);
        cmp_count++;
        if (gerr !== x.err || (x.chk && got !== x.data)) begin
            n_fail++;
            $display("ERROR %0t bus got %h/%b want %h/%b", $time, got, gerr, x.data, x.err);
        end
    endtask
    task automatic chk_bit(input logic got, input logic want, input string what);
        cmp_count++;
        if (got !== want) begin
            n_fail++;
            $display("ERROR %0t %s is %b, want %b", $time, what, got, want);
        end
    endtask
    // Note the expectation first, then run one APB transfer and wait for pready
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
            input logic [31:0] x, input logic err);
        exp_q.push_back('{data: x, err: err, chk: !w});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        @(posedge core_clk_i);
        while (pready_o !== 1'b1) @(posedge core_clk_i);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '0, 1'b0);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
        apb(1'b0, a, '0, x, 1'b0);
    endtask
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles >= 20000) begin
            n_fail++;
            test_done();
        end
        if (pready_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("ERROR %0t unexpected pready", $time);
            end else begin
                e = exp_q.pop_front();
                chk_bus(prdata_o, pslverr_o, e);
            end
        end
    end
    initial begin
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        chk_bit(low_osc_o, 1'b1, "low osc");
        chk_bit(irq_o, 1'b0, "irq");
        rd(CTL_ADDR, 32'h0000_0000);
        rd(FLG_ADDR, 32'h0000_0000);
        apb(1'b0, 20'h00010, '0, '0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(IEN_ADDR, v);
            rd(IEN_ADDR, v & 32'h0000_03FF);
        end
        wr(MS_ADDR, 32'hFFFF_BBBB);
        rd(MS_ADDR, 32'h0000_3B3B);
        wr(HR_ADDR, 32'hFFFF_FFD7);
        rd(HR_ADDR, 32'h0000_0097);
        // One second of counting from 23:59:59 wraps every field at once
        wr(CTL_ADDR, 32'h0000_0001);
        repeat (150) @(posedge core_clk_i);
        wr(CTL_ADDR, 32'h0000_0000);
        rd(MS_ADDR, 32'h0000_0000);
        rd(HR_ADDR, 32'h0000_0000);
        rd(FLG_ADDR, 32'h0000_03FF);
        wr(FLG_ADDR, 32'h0000_0000);
        rd(FLG_ADDR, 32'h0000_03FF);
        wr(FLG_ADDR, 32'h0000_000F);
        rd(FLG_ADDR, 32'h0000_03F0);
        wr(IEN_ADDR, 32'h0000_0000);
        repeat (3) @(posedge core_clk_i);
        chk_bit(irq_o, 1'b0, "irq");
        wr(IEN_ADDR, 32'h0000_0200);
        repeat (3) @(posedge core_clk_i);
        chk_bit(irq_o, 1'b1, "irq");
        chk_bit(wake_o, 1'b0, "wake");
        cpu_halt <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        chk_bit(wake_o, 1'b1, "wake");
        cpu_halt <= 1'b0;
        cpu_sleep <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        chk_bit(low_osc_o, 1'b0, "low osc");
        chk_bit(high_osc_o, 1'b0, "high osc");
        chk_bit(wake_o, 1'b0, "wake");
        wr(CTL_ADDR, 32'h0000_0001);
        repeat (3) @(posedge core_clk_i);
        chk_bit(low_osc_o, 1'b1, "low osc");
        chk_bit(high_osc_o, 1'b0, "high osc");
        chk_bit(wake_o, 1'b1, "wake");
        cpu_sleep <= 1'b0;
        wr(FLG_ADDR, 32'h0000_03FF);
        repeat (3) @(posedge core_clk_i);
        chk_bit(irq_o, 1'b0, "irq");
        // BCD 12-hour: 11:59:59 AM rolls to 00:00:00 PM
        wr(CTL_ADDR, 32'h0000_0030);
        rd(CTL_ADDR, 32'h0000_0030);
        wr(MS_ADDR, 32'h0000_5959);
        wr(HR_ADDR, 32'h0000_0011);
        wr(FLG_ADDR, 32'h0000_03FF);
        wr(CTL_ADDR, 32'h0000_0031);
        repeat (150) @(posedge core_clk_i);
        wr(CTL_ADDR, 32'h0000_0030);
        rd(HR_ADDR, 32'h0000_0080);
        rd(MS_ADDR, 32'h0000_0000);
        rd(FLG_ADDR, 32'h0000_01FF);
        // Clock enable low must hold the oscillator enables where they were
        ce_i <= 1'b0;
        cpu_sleep <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        chk_bit(low_osc_o, 1'b1, "frozen low osc");
        ce_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        chk_bit(low_osc_o, 1'b0, "low osc");
        cpu_sleep <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        test_done();
    end
endmodule
`default_nettype wire
